// file: adtb_cfg.svh
`ifndef ADTB_CFG_SVH
`define ADTB_CFG_SVH

`define ADTB_ADDR_W        16
`define ADTB_MAX_ADDR      16'hffff
`define ADTB_CH_SIGN_POS   8'h20
`define ADTB_CH_SIGN_NEG   8'h2d
`define ADTB_CH_POINT      8'h2e
`define ADTB_CH_ZERO       8'h30
`define ADTB_CH_NINE       8'h39
`define ADTB_CH_TERM       8'h00
`define ADTB_MIN_CHARS     5'h02
`define ADTB_MAX_CHARS_16  5'h08
`define ADTB_MAX_CHARS_32  5'h0d
`define ADTB_MAX_FRAC_16   5'h05
`define ADTB_MAX_FRAC_32   5'h0a
`define ADTB_FRAC_MARGIN   5'h03
`define ADTB_ERR_CODE      16'h1a32
`define ADTB_POS_LIMIT     34'h00_7fff_ffff
`define ADTB_NEG_LIMIT     34'h00_8000_0000
`define ADTB_POS_LIMIT_16  34'h00_0000_7fff
`define ADTB_NEG_LIMIT_16  34'h00_0000_8000
`define ADTB_MAG_GUARD     34'h00_0ccc_cccc
`define ADTB_MAG_SAT       34'h01_0000_0000

`endif

// file: adtb_pkg.sv
package adtb_pkg;
	typedef enum logic [2:0]
	{
		ADTB_IDLE  = 3'b000,
		ADTB_REQ   = 3'b001,
		ADTB_WAIT  = 3'b010,
		ADTB_CHAR  = 3'b011,
		ADTB_WRITE = 3'b100,
		ADTB_DONE  = 3'b101
	} adtb_state_t;

	typedef enum logic [1:0]
	{
		ADTB_WR_CNT  = 2'b00,
		ADTB_WR_FRAC = 2'b01,
		ADTB_WR_LO   = 2'b10,
		ADTB_WR_HI   = 2'b11
	} adtb_wr_t;
endpackage : adtb_pkg

// file: adtb_char_class.sv
`timescale 1ns/1ps
`include "adtb_cfg.svh"

module adtb_char_class
	import adtb_pkg::*;
(
	input  wire logic [7:0] ch_i,
	input  wire logic       first_i,
	output logic            is_term_o,
	output logic            is_digit_o,
	output logic            is_point_o,
	output logic            is_space_o,
	output logic            is_neg_o,
	output logic            bad_o
);
	always_comb
	begin
		is_term_o  = (ch_i == `ADTB_CH_TERM);
		is_digit_o = (ch_i >= `ADTB_CH_ZERO) && (ch_i <= `ADTB_CH_NINE);
		is_point_o = (ch_i == `ADTB_CH_POINT);
		is_space_o = (ch_i == `ADTB_CH_SIGN_POS);
		is_neg_o   = (ch_i == `ADTB_CH_SIGN_NEG);
		if (first_i)
			bad_o = !(is_space_o || is_neg_o);
		else
			bad_o = !(is_digit_o || is_point_o || is_space_o || is_term_o);
	end
endmodule : adtb_char_class

// file: adtb_convert.sv
`timescale 1ns/1ps
`include "adtb_cfg.svh"

// Notes on behaviour
// - Read bytes low first until zero byte
// - Write total count then fraction count
// - Fraction count is all bytes after point
// - 16-bit: counts 3..8, fraction 0..5
// - 32-bit: counts 3..13, fraction 0..10, two words
// - Fraction must not exceed count minus three
// - First byte must be space or minus
// - Later bytes: digits, space, point only
// - Minus after first byte is an error
// - Two or more points is an error
// - Value ignores point, leading blanks; negate
// - Value must fit signed mode range
// - Missing terminator before range end errors
// - Errors set flag and error-code word
module adtb_convert
	import adtb_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        convert_string_16,
	input  wire logic        convert_string_16_pulse,
	input  wire logic        convert_string_32,
	input  wire logic        convert_string_32_pulse,
	input  wire logic [15:0] src_addr_i,
	input  wire logic [15:0] cnt_addr_i,
	input  wire logic [15:0] val_addr_i,
	output logic             mem_rd_o,
	output logic [15:0]      mem_addr_o,
	input  wire logic        mem_rvalid_i,
	input  wire logic [15:0] mem_rdata_i,
	output logic             mem_wr_o,
	output logic [15:0]      mem_wdata_o,
	input  wire logic        mem_ready_i,
	output logic [15:0]      count_out_word,
	output logic [15:0]      value_out_word,
	output logic             operation_error_flag,
	output logic [15:0]      error_code_word,
	output logic             busy_o,
	output logic             done_o
);
	adtb_state_t state;
	adtb_wr_t    wr_sel;
	logic [15:0] word_addr;
	logic [15:0] word_buf;
	logic        hi_byte;
	logic [4:0]  n_chars;
	logic [4:0]  n_frac;
	logic        mode32;
	logic        seen_point;
	logic        err;
	logic [33:0] mag;
	logic        neg;
	logic        req16_q;
	logic        req32_q;
	logic [7:0]  ch;
	logic        c_term;
	logic        c_digit;
	logic        c_point;
	logic        c_space;
	logic        c_neg;
	logic        c_bad;
	logic        start;
	logic        start32;
	logic        edge16;
	logic        edge32;
	logic [4:0]  max_chars;
	logic [4:0]  max_frac;
	logic [33:0] mag_limit;
	logic        cnt_err;
	logic        rng_err;
	logic [33:0] next_mag;
	logic [31:0] signed_val;

	assign ch      = hi_byte ? word_buf[15:8] : word_buf[7:0];
	assign edge16  = convert_string_16_pulse && !req16_q;
	assign edge32  = convert_string_32_pulse && !req32_q;
	assign start32 = convert_string_32 || edge32;
	assign start   = convert_string_16 || edge16 || start32;

	adtb_char_class u_class
	(
		.ch_i       (ch),
		.first_i    (n_chars == 5'h00),
		.is_term_o  (c_term),
		.is_digit_o (c_digit),
		.is_point_o (c_point),
		.is_space_o (c_space),
		.is_neg_o   (c_neg),
		.bad_o      (c_bad)
	);

	// Saturate above every limit before the product could wrap past 34 bits
	always_comb
	begin
		next_mag = `ADTB_MAG_SAT;
		if (mag <= `ADTB_MAG_GUARD)
			next_mag = 34'((mag * 34'h0_0000_000a) + {30'h0, ch[3:0]});
	end

	always_comb
	begin
		max_chars = mode32 ? `ADTB_MAX_CHARS_32 : `ADTB_MAX_CHARS_16;
		max_frac  = mode32 ? `ADTB_MAX_FRAC_32 : `ADTB_MAX_FRAC_16;
		if (mode32)
			mag_limit = neg ? `ADTB_NEG_LIMIT : `ADTB_POS_LIMIT;
		else
			mag_limit = neg ? `ADTB_NEG_LIMIT_16 : `ADTB_POS_LIMIT_16;
		cnt_err = (n_chars < `ADTB_MIN_CHARS) || (n_chars > max_chars)
			|| (n_frac > max_frac)
			|| (n_chars < `ADTB_FRAC_MARGIN)
			|| (n_frac > 5'(n_chars - `ADTB_FRAC_MARGIN));
		rng_err = (mag > mag_limit);
		signed_val = neg ? 32'(-mag[31:0]) : mag[31:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			req16_q <= 1'b0;
			req32_q <= 1'b0;
		end
		else
		begin
			req16_q <= convert_string_16_pulse;
			req32_q <= convert_string_32_pulse;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state      <= ADTB_IDLE;
			wr_sel     <= ADTB_WR_CNT;
			word_addr  <= 16'h0000;
			word_buf   <= 16'h0000;
			hi_byte    <= 1'b0;
			n_chars    <= 5'h00;
			n_frac     <= 5'h00;
			mode32     <= 1'b0;
			seen_point <= 1'b0;
			err        <= 1'b0;
			mag        <= 34'h0;
			neg        <= 1'b0;
		end
		else
		begin
			case (state)
				ADTB_IDLE:
				begin
					if (start)
					begin
						mode32     <= start32;
						word_addr  <= src_addr_i;
						hi_byte    <= 1'b0;
						n_chars    <= 5'h00;
						n_frac     <= 5'h00;
						seen_point <= 1'b0;
						err        <= 1'b0;
						mag        <= 34'h0;
						neg        <= 1'b0;
						state      <= ADTB_REQ;
					end
				end
				ADTB_REQ:
					state <= ADTB_WAIT;
				ADTB_WAIT:
				begin
					if (mem_rvalid_i)
					begin
						word_buf <= mem_rdata_i;
						state    <= ADTB_CHAR;
					end
				end
				ADTB_CHAR:
				begin
					if (c_term)
					begin
						state  <= ADTB_WRITE;
						wr_sel <= ADTB_WR_CNT;
					end
					else
					begin
						if (n_chars != 5'h1f)
							n_chars <= n_chars + 5'h01;
						if (c_bad || (c_point && seen_point))
							err <= 1'b1;
						if (n_chars == 5'h00)
							neg <= c_neg;
						if (c_point)
							seen_point <= 1'b1;
						if (seen_point && n_frac != 5'h1f)
							n_frac <= n_frac + 5'h01;
						if (c_digit)
							mag <= next_mag;
						hi_byte <= !hi_byte;
						if (hi_byte)
						begin
							if (word_addr == `ADTB_MAX_ADDR)
							begin
								err   <= 1'b1;
								state <= ADTB_DONE;
							end
							else
							begin
								word_addr <= word_addr + 16'h0001;
								state     <= ADTB_REQ;
							end
						end
					end
				end
				ADTB_WRITE:
				begin
					if (err || cnt_err || rng_err)
					begin
						err   <= 1'b1;
						state <= ADTB_DONE;
					end
					else if (mem_ready_i)
					begin
						case (wr_sel)
							ADTB_WR_CNT:  wr_sel <= ADTB_WR_FRAC;
							ADTB_WR_FRAC: wr_sel <= ADTB_WR_LO;
							ADTB_WR_LO:
							begin
								if (mode32)
									wr_sel <= ADTB_WR_HI;
								else
									state <= ADTB_DONE;
							end
							default:      state <= ADTB_DONE;
						endcase
					end
				end
				ADTB_DONE:
					state <= ADTB_IDLE;
				default:
					state <= ADTB_IDLE;
			endcase
		end
	end

	always_comb
	begin
		mem_rd_o    = (state == ADTB_REQ);
		mem_wr_o    = (state == ADTB_WRITE) && !(err || cnt_err || rng_err);
		mem_addr_o  = word_addr;
		mem_wdata_o = 16'h0000;
		if (state == ADTB_WRITE)
		begin
			case (wr_sel)
				ADTB_WR_CNT:
				begin
					mem_addr_o  = cnt_addr_i;
					mem_wdata_o = {11'h0, n_chars};
				end
				ADTB_WR_FRAC:
				begin
					mem_addr_o  = 16'(cnt_addr_i + 16'h0001);
					mem_wdata_o = {11'h0, n_frac};
				end
				ADTB_WR_LO:
				begin
					mem_addr_o  = val_addr_i;
					mem_wdata_o = signed_val[15:0];
				end
				default:
				begin
					mem_addr_o  = 16'(val_addr_i + 16'h0001);
					mem_wdata_o = signed_val[31:16];
				end
			endcase
		end
		busy_o = (state != ADTB_IDLE);
		done_o = (state == ADTB_DONE);
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			count_out_word       <= 16'h0000;
			value_out_word       <= 16'h0000;
			operation_error_flag <= 1'b0;
			error_code_word      <= 16'h0000;
		end
		else if (state == ADTB_DONE)
		begin
			operation_error_flag <= err;
			if (err)
				error_code_word <= `ADTB_ERR_CODE;
			else
			begin
				count_out_word <= {11'h0, n_chars};
				value_out_word <= signed_val[15:0];
			end
		end
	end
endmodule : adtb_convert

// file: adtb_checker.sv
`timescale 1ns/1ps
module adtb_checker
	import adtb_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        convert_string_16,
	input  wire logic        convert_string_16_pulse,
	input  wire logic        convert_string_32,
	input  wire logic        convert_string_32_pulse,
	input  wire logic        mem_rd_o,
	input  wire logic        mem_wr_o,
	input  wire logic [15:0] mem_wdata_o,
	input  wire logic        mem_ready_i,
	input  wire logic [15:0] count_out_word,
	input  wire logic [15:0] value_out_word,
	input  wire logic        operation_error_flag,
	input  wire logic [15:0] error_code_word,
	input  wire logic        busy_o,
	input  wire logic        done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic go;
	assign go = convert_string_16 | convert_string_16_pulse | convert_string_32
		| convert_string_32_pulse;
	a_err_code: assert property (operation_error_flag |-> error_code_word == 16'h1a32)
		else $error("error code word wrong");
	a_done_once: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	a_rd_pulse: assert property (mem_rd_o |=> !mem_rd_o)
		else $error("read request too long");
	a_idle_quiet: assert property (!busy_o |-> !mem_rd_o && !mem_wr_o)
		else $error("memory access while idle");
	a_wr_hold: assert property (mem_wr_o && !mem_ready_i |=> mem_wr_o && $stable(mem_wdata_o))
		else $error("write dropped before ready");
	a_cnt_range: assert property ($changed(count_out_word) |-> count_out_word inside {[2:13]})
		else $error("count out of range");
	a_err_keep: assert property ($rose(operation_error_flag) |-> $stable(value_out_word))
		else $error("value changed on error");
	a_start_cause: assert property ($rose(busy_o) |-> $past(go))
		else $error("run without request");
	c_err: cover property ($rose(operation_error_flag));
	c_repeat: cover property (done_o ##2 $rose(busy_o));
	c_clear: cover property ($fell(operation_error_flag));
	c_stall: cover property (mem_wr_o && !mem_ready_i);
endmodule : adtb_checker

bind adtb_convert adtb_checker u_chk (.*);

// file: adtb_mem_model.sv
`timescale 1ns/1ps
module adtb_mem_model
(
	input  wire logic        clk_i,
	input  wire logic [1:0]  lat_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        wr_i,
	input  wire logic [15:0] wdata_i,
	output logic             rvalid_o = 1'b0,
	output logic [15:0]      rdata_o,
	output logic             ready_o
);
	logic [15:0] mem [256];
	logic [15:0] ra;
	logic [1:0]  rc;
	logic [1:0]  wc = 2'h0;
	logic        rp = 1'b0;
	assign ready_o = wr_i && wc == lat_i;
	// Read data is only valid with rvalid; otherwise it toggles
	always_ff @(posedge clk_i)
	begin
		rvalid_o <= 1'b0;
		rdata_o  <= ~rdata_o;
		if (rd_i)
		begin
			rp <= 1'b1;
			rc <= 2'h0;
			ra <= addr_i;
		end
		else if (rp && rc == lat_i)
		begin
			rp       <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o  <= mem[ra[7:0]];
		end
		else
			rc <= rc + 2'h1;
	end
	always @(posedge clk_i)
	begin
		wc <= ready_o ? 2'h0 : wc + {1'b0, wr_i};
		if (ready_o)
			mem[addr_i[7:0]] <= wdata_i;
	end
endmodule : adtb_mem_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
	import adtb_pkg::*;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [3:0]  st = 4'h0;
	logic [1:0]  lat = 2'h0;
	logic        mem_rd_o, mem_rvalid_i, mem_wr_o, mem_ready_i, busy_o, done_o;
	logic        operation_error_flag;
	logic [15:0] mem_addr_o, mem_rdata_i, mem_wdata_o, count_out_word, value_out_word;
	logic [15:0] error_code_word;
	int          fails = 0;
	int          total_checks = 0;
	int          cyc = 0;
	wire logic   convert_string_16 = st[0];
	wire logic   convert_string_16_pulse = st[1];
	wire logic   convert_string_32 = st[2];
	wire logic   convert_string_32_pulse = st[3];
	logic [15:0] src_addr_i = 16'h10;
	wire [15:0]  cnt_addr_i = 16'h40;
	wire [15:0]  val_addr_i = 16'h50;
	always #25 clk_i = ~clk_i;
	adtb_convert u_dut (.*);
	adtb_mem_model u_mem (.clk_i(clk_i), .lat_i(lat), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
		.wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rvalid_o(mem_rvalid_i),
		.rdata_o(mem_rdata_i), .ready_o(mem_ready_i));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		total_checks++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic conv(input logic [3:0] m, input string s, input logic e,
		input logic [4:0] c, input logic [4:0] f, input logic [31:0] v);
		int i;
		for (i = 0; i < 16; i++)
			u_mem.mem[8'h10 + i] = 16'h0;
		u_mem.mem[8'h40] = 16'hbeef;
		u_mem.mem[8'h41] = 16'hbeef;
		u_mem.mem[8'h50] = 16'hbeef;
		u_mem.mem[8'h51] = 16'hbeef;
		for (i = 0; i < s.len(); i++)
			u_mem.mem[8'h10 + i / 2][8 * (i % 2) +: 8] = s[i];
		@(negedge clk_i);
		st = m;
		@(negedge clk_i);
		st = m & 4'h5;
		for (i = 0; i < 600 && done_o !== 1'b1; i++)
			@(negedge clk_i);
		st = 4'h0;
		repeat (2) @(negedge clk_i);
		chk("flag", {15'h0, e}, {15'h0, operation_error_flag});
		if (e)
		begin
			chk("code", 16'h1a32, error_code_word);
			chk("no write", 16'hbeef, u_mem.mem[8'h40]);
			chk("no value write", 16'hbeef, u_mem.mem[8'h50]);
		end
		else
		begin
			chk("count", {11'h0, c}, u_mem.mem[8'h40]);
			chk("count out", {11'h0, c}, count_out_word);
			chk("frac", {11'h0, f}, u_mem.mem[8'h41]);
			chk("value", v[15:0], u_mem.mem[8'h50]);
			chk("value out", v[15:0], value_out_word);
			if (m[3:2] != 2'h0)
				chk("value hi", v[31:16], u_mem.mem[8'h51]);
		end
	endtask : conv
	task automatic t_values;
		conv(4'h2, "-123.45", 1'b0, 5'h7, 5'h2, 32'hffffcfc7);
		conv(4'h4, "-12345.678", 1'b0, 5'ha, 5'h3, 32'hff439eb2);
		conv(4'h1, " 00 7", 1'b0, 5'h5, 5'h0, 32'h7);
	endtask : t_values
	task automatic t_limits;
		conv(4'h1, " 32768", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h1, "-32768", 1'b0, 5'h6, 5'h0, 32'hffff8000);
		conv(4'h8, " 2147483648", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h4, " 17179869190", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h8, "-2147483648", 1'b0, 5'hb, 5'h0, 32'h80000000);
		conv(4'h1, " 1", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h1, " 00000007", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h4, " 000000000007", 1'b0, 5'hd, 5'h0, 32'h7);
	endtask : t_limits
	task automatic t_codes;
		conv(4'h1, "+12", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h1, " 1a", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h1, " 1-2", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h1, " 1.2.3", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h1, " .12", 1'b1, 5'h0, 5'h0, 32'h0);
		conv(4'h2, " 1.23", 1'b0, 5'h5, 5'h2, 32'h7b);
	endtask : t_codes
	task automatic t_repeat;
		int i;
		int n;
		conv(4'h1, " 12", 1'b0, 5'h3, 5'h0, 32'hc);
		n = 0;
		st = 4'h2;
		for (i = 0; i < 200; i++)
		begin
			@(negedge clk_i);
			if (done_o === 1'b1)
				n++;
		end
		st = 4'h1;
		chk("pulse runs", 16'h1, 16'(n));
		n = 0;
		for (i = 0; i < 200; i++)
		begin
			@(negedge clk_i);
			if (done_o === 1'b1)
				n++;
		end
		st = 4'h0;
		chk("level runs", 16'h1, {15'h0, n > 1});
		while (busy_o !== 1'b0)
			@(negedge clk_i);
		repeat (2) @(negedge clk_i);
	endtask : t_repeat
	task automatic t_no_term;
		u_mem.mem[8'h40] = 16'hbeef;
		u_mem.mem[8'hfe] = 16'h3120;
		u_mem.mem[8'hff] = 16'h3332;
		src_addr_i = 16'hfffe;
		@(negedge clk_i);
		st = 4'h2;
		@(negedge clk_i);
		st = 4'h0;
		while (done_o !== 1'b1)
			@(negedge clk_i);
		repeat (2) @(negedge clk_i);
		src_addr_i = 16'h10;
		chk("end flag", 16'h1, {15'h0, operation_error_flag});
		chk("end code", 16'h1a32, error_code_word);
		chk("end no write", 16'hbeef, u_mem.mem[8'h40]);
	endtask : t_no_term
	task automatic wrap_up;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (20) @(negedge clk_i);
		srst_i = 1'b0;
		t_values();
		lat = 2'h2;
		t_limits();
		t_codes();
		t_repeat();
		t_no_term();
		wrap_up();
	end
endmodule : tb
